/* console_model.sv */
`timescale 1ns/10ps
module console_model (
    input  wire logic                   clk,
    input  wire selftest_pkg::con_msg_t msg,
    input  wire logic                   slow,
    output logic                        ready,
    output logic                        rx_v,
    output logic [7:0]                  rx_d
);
import selftest_pkg::*;
logic [7:0] q[$];
initial {ready, rx_v, rx_d} = '0;
// Idle data toggles every cycle, starting from the inverse of the last byte, so stale characters cannot pass.
always @(posedge clk)
begin
    ready <= slow ? ~ready : 1'b1;
    if (msg.valid && ready && msg.kind == MSG_TST_ERR)
        q.push_back(CH_CR);
    rx_v <= q.size() != 0;
    rx_d <= q.size() != 0 ? q.pop_front() : ~rx_d;
end
endmodule

/* selftest_pkg.sv */
package selftest_pkg;

    // ======
    // Register map (byte addresses, one word each)
    // ======
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATE    = 8'h04;
    localparam logic [7:0] REG_INT_STAT = 8'h08;
    localparam logic [7:0] REG_INT_MASK = 8'h0C;
    localparam logic [7:0] REG_MEM_SIZE = 8'h10;
    localparam logic [7:0] REG_CFG_ADDR = 8'h14;
    localparam logic [7:0] REG_CFG_DATA = 8'h18;

    // ======
    // Interrupt event bit positions
    // ======
    localparam int EV_CTEST_FAIL = 0;
    localparam int EV_RELOAD     = 1;
    localparam int EV_HW_FAIL    = 2;
    localparam int EV_MENU       = 3;
    localparam int EV_SELECT     = 4;
    localparam int EV_W          = 5;

    // ======
    // Indicator patterns, order {first, second, third}
    // ======
    localparam logic [2:0] PAT_OK      = 3'h0;
    localparam logic [2:0] PAT_DMA     = 3'h1;
    localparam logic [2:0] PAT_RSVD    = 3'h2;
    localparam logic [2:0] PAT_CPU     = 3'h3;
    localparam logic [2:0] PAT_RAM     = 3'h4;
    localparam logic [2:0] PAT_ROM     = 3'h5;
    localparam logic [2:0] PAT_PERIPH  = 3'h6;
    localparam logic [2:0] PAT_CFG_SUM = 3'h7;

    // ======
    // Configuration store layout and factory image
    // ======
    localparam int          CFG_WORDS     = 8;
    localparam logic [2:0]  CFG_IDX_VER   = 3'h0;
    localparam logic [2:0]  CFG_IDX_DISK0 = 3'h1;
    localparam logic [2:0]  CFG_IDX_FLOP0 = 3'h2;
    localparam logic [2:0]  CFG_IDX_SUM   = 3'h7;
    // Disk word: {enable, heads[6:0], cylinders[7:0]} all zero geometry.
    localparam logic [15:0] CFG_DISK0_DEF = 16'h8000;
    // Floppy word: {enable, 13'h0, type[1:0]}, type 1 is the 8 inch drive.
    localparam logic [15:0] CFG_FLOP0_DEF = 16'h8001;

    // ======
    // Messages and console characters
    // ======
    localparam int         MSG_DEPTH  = 8;
    localparam logic [7:0] MSG_TST_OK  = 8'h01;
    localparam logic [7:0] MSG_TST_ERR = 8'h02;
    localparam logic [7:0] CH_CR      = 8'h0D;
    localparam logic [7:0] CH_S_UP    = 8'h53;
    localparam logic [7:0] CH_S_LO    = 8'h73;
    localparam logic [7:0] CH_ZERO    = 8'h30;
    localparam logic [7:0] CH_NINE    = 8'h39;
    localparam logic [7:0] UNIT_LIMIT = 8'h10;

    typedef enum logic [3:0] {
        ST_CLEAR  = 4'b0000,
        ST_CTEST  = 4'b0001,
        ST_HOLD   = 4'b0010,
        ST_VER    = 4'b0011,
        ST_RELOAD = 4'b0100,
        ST_HWT    = 4'b0101,
        ST_HWW    = 4'b0110,
        ST_CSUM   = 4'b0111,
        ST_EMIT   = 4'b1000,
        ST_WCR    = 4'b1001,
        ST_MENU   = 4'b1010,
        ST_INPUT  = 4'b1011,
        ST_BOOT   = 4'b1100,
        ST_MON    = 4'b1101
    } seq_t;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] kind;
        logic [7:0] bcd;
    } con_msg_t;

    typedef struct packed {
        seq_t        st;
        logic [2:0]  lamp;
        logic        sticky;
        logic        warm;
        logic        ret_emit;
        logic [2:0]  idx;
        logic [3:0]  mcnt;
        logic [3:0]  mrd;
        logic [7:0]  acc;
        logic        have_dig;
        logic        sel_s;
        con_msg_t    msg;
        logic        menu_v;
        logic        mon_line;
        logic        hw_go;
        logic        boot;
        logic        monitor;
        logic [3:0]  boot_unit;
        logic [3:0]  ctrl_unit;
        logic [15:0] mem_words;
        logic [2:0]  cfg_addr;
        logic [EV_W-1:0] isr;
        logic [EV_W-1:0] imr;
        logic [31:0] prdata;
        logic        pslverr;
        logic [1:0]  hr_s;
        logic [1:0]  jp_s;
    } state_t;

endpackage

/* selftest_seq.sv */
// How it works
// [RULE1] Three lamps: none, DMA 001, reserved 010, processor 011.
// [RULE2] RAM 100, ROM checksum 101, peripheral 110, config checksum 111.
// [RULE3] Board lamps and panel lamps always show the same pattern.
// [RULE4] Controller self-test runs first after any reset.
// [RULE5] Only a clean controller test advances; a fault pattern is held.
// [RULE6] Compare ROM version with stored version; match goes to hardware test.
// [RULE7] Mismatch copies the factory image over the whole configuration store.
// [RULE8] After a reload all three lamps stay lit until reset.
// [RULE9] Host reset restarts the sequence from the very start.
// [RULE10] Factory image: fixed disk on, zero geometry; floppy on, 8 inch.
// [RULE11] Messages are buffered and sent only just before the menu.
// [RULE12] Hardware test pass message buffered only after a power-off start.
// [RULE13] Hardware test failure buffers an error message instead.
// [RULE14] Menu reports installed memory size in words.
// [RULE15] Operator types S then CR for monitor, or unit then CR to boot.
// [RULE16] Jumper fitted: boot directly and drop the monitor menu line.
// [RULE17] Error message carries a decimal number; CR continues.
// [RULE18] Config checksum failure reloads defaults and lights all lamps.
// [RULE19] All lamps are cleared when each self-test run starts.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/10ps
module selftest_seq
#(
    parameter logic [15:0] FW_VERSION = 16'h0001
)
(
    input  wire logic                   I_SYS_CLK,
    input  wire logic                   I_RST,
    input  wire selftest_pkg::apb_req_t I_APB,
    output logic                        O_PREADY,
    output logic [31:0]                 O_PRDATA,
    output logic                        O_PSLVERR,
    output logic                        O_IRQ,
    input  wire logic                   I_HOST_RST,
    input  wire logic                   I_MONITOR_DISABLE_JUMPER,
    input  wire logic                   I_CTEST_DONE,
    input  wire logic [5:0]             I_CTEST_FAULTS,
    output logic                        O_HWTEST_START,
    input  wire logic                   I_HWTEST_DONE,
    input  wire logic                   I_HWTEST_FAIL,
    input  wire logic [7:0]             I_HWTEST_ERRNUM,
    output selftest_pkg::con_msg_t      O_CON_MSG,
    input  wire logic                   I_CON_MSG_READY,
    output logic                        O_MENU_VALID,
    output logic [15:0]                 O_MENU_MEM_WORDS,
    output logic                        O_MENU_MONITOR_LINE,
    input  wire logic                   I_CON_RX_VALID,
    input  wire logic [7:0]             I_CON_RX_DATA,
    output logic                        O_BOOT_HOST,
    output logic [3:0]                  O_BOOT_UNIT,
    output logic                        O_ENTER_MONITOR,
    output logic                        O_BOARD_FAULT_LAMP_A,
    output logic                        O_BOARD_FAULT_LAMP_B,
    output logic                        O_BOARD_FAULT_LAMP_C,
    output logic                        O_PANEL_LAMP_1,
    output logic                        O_PANEL_LAMP_2,
    output logic                        O_PANEL_LAMP_3
);
    import selftest_pkg::*;

    // ==========================================================
    // Helpers
    // ==========================================================
    // Fault flags {cfg, periph, rom, ram, cpu, dma}; the worst wins.
    function automatic logic [2:0] fault_pattern(input logic [5:0] f);
        logic [2:0] p;
        p = PAT_OK;
        if (f[0]) p = PAT_DMA;
        if (f[1]) p = PAT_CPU;
        if (f[2]) p = PAT_RAM;
        if (f[3]) p = PAT_ROM;
        if (f[4]) p = PAT_PERIPH;
        if (f[5]) p = PAT_CFG_SUM;
        return p;
    endfunction

    function automatic logic [15:0] cfg_default(input logic [2:0] i);
        logic [15:0] w;
        case (i)
            CFG_IDX_VER:   w = FW_VERSION;
            CFG_IDX_DISK0: w = CFG_DISK0_DEF;
            CFG_IDX_FLOP0: w = CFG_FLOP0_DEF;
            CFG_IDX_SUM:   w = FW_VERSION ^ CFG_DISK0_DEF ^ CFG_FLOP0_DEF;
            default:       w = 16'h0000;
        endcase
        return w;
    endfunction

    function automatic logic [7:0] to_bcd(input logic [7:0] n);
        logic [7:0] m;
        logic [7:0] t;
        m = n % 8'd100;
        t = m / 8'd10;
        return {t[3:0], 4'(m - t * 8'd10)};
    endfunction

    // ==========================================================
    // State and memories
    // ==========================================================
    state_t      s_q;
    state_t      s_d;
    logic [15:0] cfg_mem [CFG_WORDS];
    logic [15:0] msg_mem [MSG_DEPTH];
    logic        cfg_we;
    logic [2:0]  cfg_wa;
    logic [15:0] cfg_wd;
    logic        msg_we;
    logic [15:0] msg_wd;
    logic        hr;
    logic        jp;
    logic        acc_w;
    logic        csum_ok;
    logic [15:0] csum;
    logic [15:0] head;
    logic [7:0]  dig;
    logic [EV_W-1:0] ev;
    logic [EV_W-1:0] clr;
    logic [7:0]  sum10;

    always_comb
    begin
        s_d    = s_q;
        cfg_we = 1'b0;
        cfg_wa = s_q.idx;
        cfg_wd = cfg_default(s_q.idx);
        msg_we = 1'b0;
        msg_wd = 16'h0000;
        ev     = '0;
        clr    = '0;
        csum   = 16'h0000;
        for (int i = 0; i < CFG_WORDS - 1; i++)
        begin
            csum = csum ^ cfg_mem[i];
        end
        csum_ok = (csum == cfg_mem[CFG_IDX_SUM]);
        head    = msg_mem[s_q.mrd[2:0]];
        dig     = I_CON_RX_DATA - CH_ZERO;
        sum10   = 8'(s_q.acc * 8'd10 + dig);
        s_d.hw_go  = 1'b0;
        s_d.menu_v = 1'b0;
        // Two flip-flops on the host reset and jumper pins before any logic looks at them.
        s_d.hr_s = {s_q.hr_s[0], I_HOST_RST};
        s_d.jp_s = {s_q.jp_s[0], I_MONITOR_DISABLE_JUMPER};
        hr = s_q.hr_s[1];
        jp = s_q.jp_s[1];

        // ======================================================
        // APB slave, zero wait states
        // ======================================================
        acc_w = I_APB.psel & I_APB.penable & I_APB.pwrite;
        if (I_APB.psel & ~I_APB.penable)
        begin
            s_d.pslverr = 1'b0;
            case (I_APB.paddr)
                REG_CTRL:     s_d.prdata = {28'h0, s_q.ctrl_unit};
                REG_STATE:    s_d.prdata = {19'h0, s_q.warm, s_q.sticky,
                                            s_q.lamp, s_q.mcnt, s_q.st};
                REG_INT_STAT: s_d.prdata = {27'h0, s_q.isr};
                REG_INT_MASK: s_d.prdata = {27'h0, s_q.imr};
                REG_MEM_SIZE: s_d.prdata = {16'h0, s_q.mem_words};
                REG_CFG_ADDR: s_d.prdata = {29'h0, s_q.cfg_addr};
                REG_CFG_DATA: s_d.prdata = {16'h0, cfg_mem[s_q.cfg_addr]};
                default:
                begin
                    s_d.prdata  = 32'h0;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        if (acc_w)
        begin
            case (I_APB.paddr)
                REG_CTRL:     s_d.ctrl_unit = I_APB.pwdata[3:0];
                REG_INT_STAT: clr = I_APB.pwdata[EV_W-1:0];
                REG_INT_MASK: s_d.imr = I_APB.pwdata[EV_W-1:0];
                REG_MEM_SIZE: s_d.mem_words = I_APB.pwdata[15:0];
                REG_CFG_ADDR: s_d.cfg_addr = I_APB.pwdata[2:0];
                REG_CFG_DATA:
                begin
                    cfg_we = 1'b1;
                    cfg_wa = s_q.cfg_addr;
                    cfg_wd = I_APB.pwdata[15:0];
                end
                default:
                begin
                end
            endcase
        end

        // ======================================================
        // Start-up sequencer
        // ======================================================
        case (s_q.st)
            // [RULE19] lamps cleared first
            ST_CLEAR:
            begin
                s_d.lamp     = PAT_OK;
                s_d.sticky   = 1'b0;
                s_d.mcnt     = 4'h0;
                s_d.mrd      = 4'h0;
                s_d.msg      = '0;
                s_d.boot     = 1'b0;
                s_d.monitor  = 1'b0;
                s_d.ret_emit = 1'b0;
                s_d.st       = ST_CTEST;
            end
            // [RULE4] controller test first
            ST_CTEST:
            begin
                if (I_CTEST_DONE)
                begin
                    // [RULE1] [RULE2] pattern encoding
                    s_d.lamp = fault_pattern(I_CTEST_FAULTS);
                    // [RULE5] advance only when clean
                    if (fault_pattern(I_CTEST_FAULTS) != PAT_OK)
                    begin
                        ev[EV_CTEST_FAIL] = 1'b1;
                        s_d.st = ST_HOLD;
                    end
                    else
                    begin
                        s_d.st = ST_VER;
                    end
                end
            end
            ST_HOLD:
            begin
                s_d.st = ST_HOLD;
            end
            // [RULE6] version compare
            ST_VER:
            begin
                s_d.idx = 3'h0;
                if (cfg_mem[CFG_IDX_VER] == FW_VERSION)
                begin
                    s_d.st = ST_HWT;
                end
                else
                begin
                    s_d.st = ST_RELOAD;
                end
            end
            // [RULE7] [RULE10] factory image copy
            ST_RELOAD:
            begin
                cfg_we  = 1'b1;
                cfg_wa  = s_q.idx;
                cfg_wd  = cfg_default(s_q.idx);
                s_d.idx = s_q.idx + 3'h1;
                if (s_q.idx == CFG_IDX_SUM)
                begin
                    // [RULE8] all lamps lit, sticky
                    s_d.sticky = 1'b1;
                    ev[EV_RELOAD] = 1'b1;
                    s_d.st = s_q.ret_emit ? ST_EMIT : ST_HWT;
                end
            end
            ST_HWT:
            begin
                s_d.hw_go = 1'b1;
                s_d.st    = ST_HWW;
            end
            ST_HWW:
            begin
                if (I_HWTEST_DONE)
                begin
                    s_d.st = ST_CSUM;
                    // [RULE13] error message
                    if (I_HWTEST_FAIL)
                    begin
                        msg_we = 1'b1;
                        msg_wd = {MSG_TST_ERR, I_HWTEST_ERRNUM};
                        ev[EV_HW_FAIL] = 1'b1;
                    end
                    // [RULE12] pass only after power-off
                    else if (!s_q.warm)
                    begin
                        msg_we = 1'b1;
                        msg_wd = {MSG_TST_OK, 8'h00};
                    end
                    if (msg_we && s_q.mcnt < 4'(MSG_DEPTH))
                    begin
                        s_d.mcnt = s_q.mcnt + 4'h1;
                    end
                    else
                    begin
                        msg_we = 1'b0;
                    end
                end
            end
            // [RULE18] checksum failure reload
            ST_CSUM:
            begin
                s_d.idx      = 3'h0;
                s_d.ret_emit = 1'b1;
                s_d.st       = csum_ok ? ST_EMIT : ST_RELOAD;
            end
            // [RULE11] drain buffer before menu
            ST_EMIT:
            begin
                if (!s_q.msg.valid)
                begin
                    if (s_q.mrd == s_q.mcnt)
                    begin
                        s_d.st = ST_MENU;
                    end
                    else
                    begin
                        s_d.msg.valid = 1'b1;
                        s_d.msg.kind  = head[15:8];
                        // [RULE17] decimal error number
                        s_d.msg.bcd   = to_bcd(head[7:0]);
                    end
                end
                else if (I_CON_MSG_READY)
                begin
                    s_d.msg.valid = 1'b0;
                    s_d.mrd = s_q.mrd + 4'h1;
                    if (s_q.msg.kind == MSG_TST_ERR)
                    begin
                        s_d.st = ST_WCR;
                    end
                end
            end
            // [RULE17] CR continues
            ST_WCR:
            begin
                if (I_CON_RX_VALID && I_CON_RX_DATA == CH_CR)
                begin
                    s_d.st = ST_EMIT;
                end
            end
            // [RULE14] [RULE16] menu contents
            ST_MENU:
            begin
                s_d.menu_v   = 1'b1;
                s_d.mon_line = ~jp;
                s_d.acc      = 8'h00;
                s_d.have_dig = 1'b0;
                s_d.sel_s    = 1'b0;
                ev[EV_MENU]  = 1'b1;
                if (jp)
                begin
                    s_d.boot_unit = s_q.ctrl_unit;
                    s_d.st = ST_BOOT;
                end
                else
                begin
                    s_d.st = ST_INPUT;
                end
            end
            // [RULE15] operator selection
            ST_INPUT:
            begin
                if (I_CON_RX_VALID)
                begin
                    if (I_CON_RX_DATA == CH_S_UP || I_CON_RX_DATA == CH_S_LO)
                    begin
                        s_d.sel_s = ~s_q.have_dig;
                    end
                    else if (I_CON_RX_DATA >= CH_ZERO && I_CON_RX_DATA <= CH_NINE)
                    begin
                        s_d.have_dig = 1'b1;
                        s_d.sel_s    = 1'b0;
                        s_d.acc = (s_q.acc >= UNIT_LIMIT) ? UNIT_LIMIT : sum10;
                    end
                    else if (I_CON_RX_DATA == CH_CR)
                    begin
                        s_d.acc      = 8'h00;
                        s_d.have_dig = 1'b0;
                        s_d.sel_s    = 1'b0;
                        if (s_q.sel_s)
                        begin
                            s_d.st = ST_MON;
                        end
                        else if (s_q.have_dig && s_q.acc < UNIT_LIMIT)
                        begin
                            s_d.boot_unit = s_q.acc[3:0];
                            s_d.st = ST_BOOT;
                        end
                    end
                    else
                    begin
                        s_d.acc      = 8'h00;
                        s_d.have_dig = 1'b0;
                        s_d.sel_s    = 1'b0;
                    end
                end
            end
            ST_BOOT:
            begin
                ev[EV_SELECT] = ~s_q.boot;
                s_d.boot = 1'b1;
            end
            ST_MON:
            begin
                ev[EV_SELECT] = ~s_q.monitor;
                s_d.monitor = 1'b1;
            end
            default:
            begin
                s_d.st = ST_CLEAR;
            end
        endcase

        if (s_d.sticky)
        begin
            s_d.lamp = PAT_CFG_SUM;
        end
        // [RULE9] host reset restarts
        if (hr)
        begin
            s_d.warm   = 1'b1;
            s_d.st     = ST_CLEAR;
            s_d.hw_go  = 1'b0;
            s_d.menu_v = 1'b0;
            msg_we     = 1'b0;
        end
        // A new event wins over a simultaneous clear.
        s_d.isr = (s_q.isr & ~clr) | ev;
    end

    always_ff @(posedge I_SYS_CLK)
    begin
        if (I_RST)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    // Stores are not reset; contents survive a reset like real storage.
    always_ff @(posedge I_SYS_CLK)
    begin
        if (cfg_we)
        begin
            cfg_mem[cfg_wa] <= cfg_wd;
        end
        if (msg_we)
        begin
            msg_mem[s_q.mcnt[2:0]] <= msg_wd;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign O_PREADY            = 1'b1;
    assign O_PRDATA            = s_q.prdata;
    assign O_PSLVERR           = s_q.pslverr & I_APB.psel & I_APB.penable;
    assign O_IRQ               = |(s_q.isr & s_q.imr);
    assign O_HWTEST_START      = s_q.hw_go;
    assign O_CON_MSG           = s_q.msg;
    assign O_MENU_VALID        = s_q.menu_v;
    assign O_MENU_MEM_WORDS    = s_q.mem_words;
    assign O_MENU_MONITOR_LINE = s_q.mon_line;
    assign O_BOOT_HOST         = s_q.boot;
    assign O_BOOT_UNIT         = s_q.boot_unit;
    assign O_ENTER_MONITOR     = s_q.monitor;
    // [RULE3] identical lamp sets
    assign O_BOARD_FAULT_LAMP_A = s_q.lamp[2];
    assign O_BOARD_FAULT_LAMP_B = s_q.lamp[1];
    assign O_BOARD_FAULT_LAMP_C = s_q.lamp[0];
    assign O_PANEL_LAMP_1       = s_q.lamp[2];
    assign O_PANEL_LAMP_2       = s_q.lamp[1];
    assign O_PANEL_LAMP_3       = s_q.lamp[0];

endmodule

/* selftest_seq_props.sv */
`timescale 1ns/10ps
module selftest_seq_props (
    input wire logic I_SYS_CLK, I_RST, I_HOST_RST, I_MONITOR_DISABLE_JUMPER, I_CTEST_DONE,
    input wire logic [5:0] I_CTEST_FAULTS,
    input wire logic O_HWTEST_START, O_MENU_VALID, O_MENU_MONITOR_LINE, O_BOOT_HOST,
    input wire logic O_ENTER_MONITOR, O_BOARD_FAULT_LAMP_A, O_BOARD_FAULT_LAMP_B,
    input wire logic O_BOARD_FAULT_LAMP_C, O_PANEL_LAMP_1, O_PANEL_LAMP_2, O_PANEL_LAMP_3
);
import selftest_pkg::*;
// ======
// Lamp and start-up sequence checks
default clocking @(posedge I_SYS_CLK); endclocking
default disable iff (I_RST);
wire [2:0] lamp = {O_BOARD_FAULT_LAMP_A, O_BOARD_FAULT_LAMP_B, O_BOARD_FAULT_LAMP_C};
// The worst fault wins.
function automatic logic [2:0] enc(input logic [5:0] f);
    return f[5] ? 3'h7 : f[4] ? 3'h6 : f[3] ? 3'h5 : f[2] ? 3'h4 : f[1] ? 3'h3 : 3'h1;
endfunction
// Four quiet samples cover the host reset synchroniser.
sequence s_quiet; !I_HOST_RST [*4]; endsequence
sequence s_held; I_HOST_RST [*4]; endsequence
property p_mirror; {O_PANEL_LAMP_1, O_PANEL_LAMP_2, O_PANEL_LAMP_3} == lamp; endproperty
a_mirror: assert property (p_mirror) else $error("lamp sets differ");
property p_enc; I_CTEST_DONE && I_CTEST_FAULTS != 6'h00 && lamp == 3'h0
    |-> ##[1:6] lamp == enc(I_CTEST_FAULTS); endproperty
a_enc: assert property (p_enc) else $error("bad fault pattern");
property p_rst; $fell(I_RST) |-> lamp == 3'h0 && !O_BOOT_HOST; endproperty
a_rst: assert property (p_rst) else $error("lamps lit at start");
property p_hold; s_quiet ##0 lamp != 3'h0 |=> $stable(lamp); endproperty
a_hold: assert property (p_hold) else $error("fault pattern lost");
property p_adv; O_HWTEST_START |-> I_CTEST_FAULTS == 6'h00; endproperty
a_adv: assert property (p_adv) else $error("advanced after fault");
property p_host; s_held |=> lamp == 3'h0 && !O_BOOT_HOST && !O_ENTER_MONITOR; endproperty
a_host: assert property (p_host) else $error("host reset ignored");
property p_line; O_MENU_VALID |-> O_MENU_MONITOR_LINE == !I_MONITOR_DISABLE_JUMPER; endproperty
a_line: assert property (p_line) else $error("monitor line wrong");
property p_jump; O_MENU_VALID && I_MONITOR_DISABLE_JUMPER |-> ##[1:6] O_BOOT_HOST; endproperty
a_jump: assert property (p_jump) else $error("no direct boot");
property p_excl; !(O_BOOT_HOST && O_ENTER_MONITOR); endproperty
a_excl: assert property (p_excl) else $error("boot and monitor both");
endmodule
bind selftest_seq selftest_seq_props u_props (.*);

/* tb_disk_ctrl_selftest_sequencer.sv */
`timescale 1ns/10ps
module tb_disk_ctrl_selftest_sequencer;
import selftest_pkg::*;
logic clk = 0, rst = 1, hrst = 0, jmp = 0, cdone = 0, hdone = 0, hfail = 0, slow = 0, er;
logic [5:0] flt = '0;
logic [7:0] enr = '0, v;
logic [15:0] mem;
logic [3:0] u;
logic [31:0] rd, q_exp[$], img[3] = '{32'h1, 32'h8000, 32'h8001};
logic [2:0] pat[6] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
int errors, n_compared;
apb_req_t apb = '0;
con_msg_t msg;
wire rdy, rxv, rdyp, irq, st, mv, ml, boot, mon, la, lb, lc, p1, p2, p3, perr;
wire [7:0] rxd;
wire [3:0] unit;
wire [15:0] mw;
wire [31:0] prd;
wire [2:0] lamp = {la, lb, lc};
selftest_seq DUT (.I_SYS_CLK(clk), .I_RST(rst), .I_APB(apb), .O_PREADY(rdyp), .O_PRDATA(prd),
    .O_PSLVERR(perr), .O_IRQ(irq), .I_HOST_RST(hrst), .I_MONITOR_DISABLE_JUMPER(jmp),
    .I_CTEST_DONE(cdone), .I_CTEST_FAULTS(flt), .O_HWTEST_START(st), .I_HWTEST_DONE(hdone),
    .I_HWTEST_FAIL(hfail), .I_HWTEST_ERRNUM(enr), .O_CON_MSG(msg), .I_CON_MSG_READY(rdy),
    .O_MENU_VALID(mv), .O_MENU_MEM_WORDS(mw), .O_MENU_MONITOR_LINE(ml), .I_CON_RX_VALID(rxv),
    .I_CON_RX_DATA(rxd), .O_BOOT_HOST(boot), .O_BOOT_UNIT(unit), .O_ENTER_MONITOR(mon),
    .O_BOARD_FAULT_LAMP_A(la), .O_BOARD_FAULT_LAMP_B(lb), .O_BOARD_FAULT_LAMP_C(lc),
    .O_PANEL_LAMP_1(p1), .O_PANEL_LAMP_2(p2), .O_PANEL_LAMP_3(p3));
console_model CON (.clk(clk), .msg(msg), .slow(slow), .ready(rdy), .rx_v(rxv), .rx_d(rxd));
always #20 clk = ~clk;
always @(posedge clk) hdone <= st;
task stop_test;
    if (errors == 0 && n_compared > 0)
        $display("bench passed");
    else
        $display("bench failed");
    $finish;
endtask
task chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
        errors++;
        $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
endtask
task take(input logic [31:0] s);
    chk(s, q_exp.size() ? q_exp.pop_front() : '1);
endtask
// ======
// Bus and restart helpers
task apb_x(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    apb <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk);
    apb.penable <= 1'b1;
    do @(posedge clk); while (rdyp !== 1'b1);
    {er, rd} = {perr, prd};
    apb <= '0;
endtask
task restart(input bit host);
    @(posedge clk);
    {hrst, rst} <= host ? 2'b10 : 2'b01;
    repeat (host ? 6 : 4) @(posedge clk);
    {hrst, rst} <= 2'b00;
endtask
always @(posedge clk)
begin
    if (msg.valid && rdy) take({8'h01, msg.kind, msg.bcd});
    if (mv) take({8'h02, 7'h00, ml, mw});
    if ($rose(boot)) take({28'h0300000, unit});
    if ($rose(mon)) take(32'h04000000);
end
initial
begin
    #400000;
    errors++;
    stop_test;
end
initial
begin
    void'($urandom(4212));
    mem = 16'($urandom);
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    apb_x(1, REG_MEM_SIZE, {16'h0000, mem});
    apb_x(1, REG_INT_MASK, 32'h1 << EV_MENU);
    apb_x(0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    chk(er, 1'b1);
    // A blank store forces a reload first.
    q_exp = '{{8'h01, MSG_TST_OK, 8'h00}, {8'h02, 8'h01, mem}, 32'h04000000};
    cdone <= 1'b1;
    wait (mv);
    repeat (2) @(posedge clk);
    chk(irq, 1'b1);
    apb_x(1, REG_INT_STAT, 32'h1 << EV_MENU);
    @(posedge clk);
    chk(irq, 1'b0);
    CON.q.push_back(CH_S_UP);
    CON.q.push_back(CH_CR);
    wait (boot | mon);
    chk(lamp, 3'h7);
    for (int i = 0; i < 3; i++)
    begin
        apb_x(1, REG_CFG_ADDR, i);
        apb_x(0, REG_CFG_DATA, 32'h0);
        chk(rd, img[i]);
    end
    v = 8'($urandom);
    u = 4'($urandom);
    enr <= v;
    hfail <= 1'b1;
    slow <= 1'b1;
    q_exp = '{{8'h01, MSG_TST_ERR, 8'(v % 100 / 10 * 16 + v % 100 % 10)}, {8'h02, 8'h01, mem},
        {28'h0300000, u}};
    restart(1);
    wait (mv);
    if (u > 9) CON.q.push_back(CH_ZERO + 8'h01);
    CON.q.push_back(CH_ZERO + 8'(u % 10));
    CON.q.push_back(CH_CR);
    wait (boot | mon);
    chk(lamp, 3'h0);
    u = 4'($urandom);
    apb_x(1, REG_CTRL, {28'h0, u});
    apb_x(1, REG_CFG_ADDR, 32'h3);
    apb_x(1, REG_CFG_DATA, 32'h5A);
    jmp <= 1'b1;
    hfail <= 1'b0;
    q_exp = '{{8'h02, 8'h00, mem}, {28'h0300000, u}};
    restart(1);
    wait (boot | mon);
    chk(lamp, 3'h7);
    jmp <= 1'b0;
    for (int k = 0; k < 6; k++)
    begin
        flt <= 6'h01 << k;
        restart(0);
        repeat (8) @(posedge clk);
        chk(lamp, pat[k]);
    end
    chk(q_exp.size(), 0);
    stop_test;
end
endmodule
